// >>> rtl/lbp_port.sv
// Purpose: byte-wide link port moving 32-bit words between two processors
// Assumes: far end is an identical port; lines released are pulled low
// Notes:   exactly one end owns the link after reset, set by OWN_AT_RESET
// Function
// - four control lines plus eight data lines
// - ends arbitrate link ownership before sending
// - request, acknowledge, then data bytes
// - each word sent as four bytes
// - send only words already in output fifo
// - assembled word goes into input fifo
// - input and output fifos, eight words each
// - local side writes out, reads in
// - fifo pair buffers sixteen words

`timescale 1ns/1ps

module lbp_port
   import lbp_pkg::*;
#(
   parameter logic OWN_AT_RESET = 1'b1,         // this end owns link first
   parameter int   DEPTH        = LBP_FIFO_DEPTH
)(
   input  wire logic                  CLK_I,
   input  wire logic                  RST_N_I,
   input  wire logic [LBP_WORD_W-1:0] TXW_DATA_I,
   input  wire logic                  TXW_VALID_I,
   output wire logic                  TXW_READY_O,
   output wire logic [LBP_WORD_W-1:0] RXW_DATA_O,
   output wire logic                  RXW_VALID_O,
   input  wire logic                  RXW_READY_I,
   input  wire logic [LBP_CTL_W-1:0]  CTL_I,
   output wire logic [LBP_CTL_W-1:0]  CTL_O,
   output wire logic [LBP_CTL_W-1:0]  CTL_OE_N_O,
   input  wire logic [LBP_BYTE_W-1:0] LD_I,
   output wire logic [LBP_BYTE_W-1:0] LD_O,
   output wire logic                  LD_OE_N_O,
   output wire logic                  OWNER_O
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      lbp_state_e            st;                // link state
      logic                  owner;             // this end drives link
      logic [2:0]            tx_cnt;            // send phase, 0 request
      logic [2:0]            rx_cnt;            // receive phase, 0 request
      logic [LBP_WORD_W-1:0] rx_word;           // word being assembled
      logic                  rx_push;           // word to input fifo
      logic [LBP_CTL_W-1:0]  ctl;               // lines asserted
      logic [LBP_CTL_W-1:0]  ctl_oe_n;          // line drivers, low drives
      logic [LBP_BYTE_W-1:0] ld;                // data byte out
      logic                  ld_oe_n;           // data drivers, low drives
      logic [LBP_CTL_W-1:0]  ctl_m;             // control sync, first
      logic [LBP_CTL_W-1:0]  ctl_s;             // control sync, second
      logic [LBP_BYTE_W-1:0] ld_m;              // data sync, first
      logic [LBP_BYTE_W-1:0] ld_s;              // data sync, second
   } lbp_core_s;

   lbp_core_s r;                                // registered state
   lbp_core_s next_r;                           // next state
   logic      tx_pop;                           // last byte acknowledged
   logic      strb_in;                          // far strobe, synced
   logic      rdy_in;                           // far answer, synced
   logic      treq_in;                          // far ownership request
   logic      tgnt_in;                          // far ownership grant

   // ----------------------------------------------------------------
   // fifos and local word ports
   // ----------------------------------------------------------------
   lbp_stream_if #(.W(LBP_WORD_W)) txw_if ();   // local writes
   lbp_stream_if #(.W(LBP_WORD_W)) txl_if ();   // words to the link
   lbp_stream_if #(.W(LBP_WORD_W)) rxl_if ();   // words from the link
   lbp_stream_if #(.W(LBP_WORD_W)) rxw_if ();   // local reads

   // local write fills output fifo, local read drains input fifo
   assign txw_if.valid = TXW_VALID_I;
   assign txw_if.data  = TXW_DATA_I;
   assign TXW_READY_O  = txw_if.ready;
   assign RXW_DATA_O   = rxw_if.data;
   assign RXW_VALID_O  = rxw_if.valid;
   assign rxw_if.ready = RXW_READY_I;
   assign txl_if.ready = tx_pop;
   assign rxl_if.valid = r.rx_push;
   assign rxl_if.data  = r.rx_word;

   // output fifo, eight words
   lbp_fifo #(.W(LBP_WORD_W), .DEPTH(DEPTH)) u_out_fifo (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .wr      (txw_if),
      .rd      (txl_if)
   );

   // input fifo, eight words
   lbp_fifo #(.W(LBP_WORD_W), .DEPTH(DEPTH)) u_in_fifo (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .wr      (rxl_if),
      .rd      (rxw_if)
   );

   // ----------------------------------------------------------------
   // link pins
   // ----------------------------------------------------------------
   assign CTL_O      = r.ctl;
   assign CTL_OE_N_O = r.ctl_oe_n;
   assign LD_O       = r.ld;
   assign LD_OE_N_O  = r.ld_oe_n;
   assign OWNER_O    = r.owner;

   assign strb_in = r.ctl_s[LBP_CTL_STRB];
   assign rdy_in  = r.ctl_s[LBP_CTL_RDY];
   assign treq_in = r.ctl_s[LBP_CTL_TREQ];
   assign tgnt_in = r.ctl_s[LBP_CTL_TGNT];
   assign tx_pop  = (r.st == LBP_S_LOW) && !rdy_in && (r.tx_cnt == LBP_PHASE_LAST);

   // next state of link logic
   always_comb
   begin
      next_r         = r;
      next_r.ctl_m   = CTL_I;
      next_r.ctl_s   = r.ctl_m;
      next_r.ld_m    = LD_I;
      next_r.ld_s    = r.ld_m;
      next_r.rx_push = 1'b0;
      // sending side and ownership
      case (r.st)
         LBP_S_IDLE:
         begin
            if (r.owner && treq_in)
            begin
               next_r.ctl[LBP_CTL_TGNT] = 1'b1;
               next_r.st                = LBP_S_GRANT;
            end
            else if (r.owner && txl_if.valid)
            begin
               next_r.tx_cnt = LBP_PHASE_REQ;
               next_r.st     = LBP_S_SETUP;
            end
            else if (!r.owner && txl_if.valid)
            begin
               next_r.ctl[LBP_CTL_TREQ] = 1'b1;
               next_r.st                = LBP_S_TREQ;
            end
         end
         LBP_S_SETUP:
         begin
            next_r.ctl[LBP_CTL_STRB] = 1'b1;
            next_r.st                = LBP_S_HIGH;
         end
         LBP_S_HIGH:
         begin
            if (rdy_in)
            begin
               next_r.ctl[LBP_CTL_STRB] = 1'b0;
               next_r.st                = LBP_S_LOW;
            end
         end
         LBP_S_LOW:
         begin
            if (!rdy_in && r.tx_cnt == LBP_PHASE_LAST)
            begin
               next_r.ld_oe_n = LBP_OE_OFF;
               next_r.tx_cnt  = LBP_PHASE_REQ;
               next_r.st      = LBP_S_IDLE;
            end
            else if (!rdy_in)
            begin
               // bytes only after the request was acknowledged
               next_r.ld      = lbp_byte_of(txl_if.data, r.tx_cnt[1:0]);
               next_r.ld_oe_n = 1'b0;
               next_r.tx_cnt  = r.tx_cnt + 3'h1;
               next_r.st      = LBP_S_SETUP;
            end
         end
         LBP_S_GRANT:
         begin
            if (!treq_in)
            begin
               next_r.ctl[LBP_CTL_TGNT] = 1'b0;
               next_r.owner             = 1'b0;
               next_r.st                = LBP_S_IDLE;
            end
         end
         LBP_S_TREQ:
         begin
            if (tgnt_in)
            begin
               next_r.ctl[LBP_CTL_TREQ] = 1'b0;
               next_r.st                = LBP_S_TACQ;
            end
         end
         LBP_S_TACQ:
         begin
            if (!tgnt_in)
            begin
               next_r.owner = 1'b1;
               next_r.st    = LBP_S_IDLE;
            end
         end
         default:
         begin
            next_r.st = LBP_S_IDLE;
         end
      endcase
      // receiving side, only while the far end owns the link
      if (!r.owner)
      begin
         if (strb_in && !r.ctl[LBP_CTL_RDY])
         begin
            if (r.rx_cnt == LBP_PHASE_REQ)
            begin
               // room for a whole word before acknowledging
               next_r.ctl[LBP_CTL_RDY] = rxl_if.ready;
            end
            else
            begin
               next_r.rx_word[{r.rx_cnt[1:0] - 2'h1, 3'h0} +: 8] = r.ld_s;
               next_r.ctl[LBP_CTL_RDY] = 1'b1;
            end
         end
         else if (!strb_in && r.ctl[LBP_CTL_RDY])
         begin
            next_r.ctl[LBP_CTL_RDY] = 1'b0;
            if (r.rx_cnt == LBP_PHASE_LAST)
            begin
               next_r.rx_cnt  = LBP_PHASE_REQ;
               next_r.rx_push = 1'b1;
            end
            else
            begin
               next_r.rx_cnt = r.rx_cnt + 3'h1;
            end
         end
      end
      next_r.ctl_oe_n = ~next_r.ctl;
   end

   // state register
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         r          <= '0;
         r.st       <= LBP_S_IDLE;
         r.owner    <= OWN_AT_RESET;
         r.ctl      <= LBP_CTL_RST;
         r.ctl_oe_n <= LBP_CTL_OFF;
         r.ld_oe_n  <= LBP_OE_OFF;
      end
      else
         r <= next_r;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_phase_ack;
      r.st == LBP_S_HIGH && rdy_in ##1 r.st == LBP_S_LOW;
   endsequence
   sequence s_grant_done;
      r.st == LBP_S_GRANT && !treq_in ##1 r.st == LBP_S_IDLE;
   endsequence

   AST_DATA_AFTER_ACK: assert property ($fell(r.ld_oe_n) |->
      $past(r.st) == LBP_S_LOW && $past(r.tx_cnt) == LBP_PHASE_REQ)
      else $error("data driven before request acknowledged");
   AST_STRB_DROP: assert property (s_phase_ack |-> !r.ctl[LBP_CTL_STRB])
      else $error("strobe kept after answer");
   AST_FOUR_BYTES: assert property (tx_pop |-> r.tx_cnt == 3'h4 && !r.ld_oe_n)
      else $error("word popped before fourth byte");
   AST_BYTE_STABLE: assert property (r.ctl[LBP_CTL_STRB] |-> $stable(r.ld))
      else $error("data byte moved under strobe");
   AST_NEED_WORD: assert property (r.st == LBP_S_IDLE && r.owner && !treq_in
      && !txl_if.valid |=> r.st == LBP_S_IDLE)
      else $error("send started from empty fifo");
   AST_PUSH_WORD: assert property (r.rx_push |-> $past(r.rx_cnt) == 3'h4
      && r.rx_cnt == 3'h0)
      else $error("word stored before four bytes");
   AST_ROOM_FIRST: assert property ($rose(r.ctl[LBP_CTL_RDY]) && r.rx_cnt == 3'h0
      |-> $past(rxl_if.ready))
      else $error("request acknowledged without room");
   AST_OWNER_DRIVES: assert property (!r.ld_oe_n || r.ctl[LBP_CTL_STRB] |-> r.owner)
      else $error("non-owner drives link");
   AST_HAND_OVER: assert property (s_grant_done |-> !r.owner && !r.ctl[LBP_CTL_TGNT])
      else $error("ownership not released after grant");
   AST_LINE_SPLIT: assert property (r.ctl[LBP_CTL_RDY] |-> !r.owner)
      else $error("owner drives answer line");
endmodule

// >>> rtl/lbp_pkg.sv
// Purpose: shared constants and types of the byte link port
// Assumes: one clock, synchronous active-low reset
// Notes:   control line indices are positions on the four-line control bus

package lbp_pkg;

   // ----------------------------------------------------------------
   // widths and depths
   // ----------------------------------------------------------------
   localparam int LBP_WORD_W     = 32;          // word width
   localparam int LBP_BYTE_W     = 8;           // link data width
   localparam int LBP_CTL_W      = 4;           // control line count
   localparam int LBP_FIFO_DEPTH = 8;           // words per fifo

   // ----------------------------------------------------------------
   // control line positions
   // ----------------------------------------------------------------
   localparam int LBP_CTL_TREQ = 0;             // ownership request
   localparam int LBP_CTL_TGNT = 1;             // ownership grant
   localparam int LBP_CTL_STRB = 2;             // phase strobe from owner
   localparam int LBP_CTL_RDY  = 3;             // phase answer from receiver

   // ----------------------------------------------------------------
   // phase counts and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] LBP_PHASE_REQ  = 3'h0; // word request phase
   localparam logic [2:0] LBP_PHASE_LAST = 3'h4; // fourth byte phase
   localparam logic [3:0] LBP_CTL_RST    = 4'h0; // no line asserted
   localparam logic [3:0] LBP_CTL_OFF    = 4'hF; // all lines released
   localparam logic       LBP_OE_OFF     = 1'b1; // data pins released

   // ----------------------------------------------------------------
   // link state machine, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      LBP_S_IDLE  = 7'h01,                      // waiting for work
      LBP_S_SETUP = 7'h02,                      // data settles before strobe
      LBP_S_HIGH  = 7'h04,                      // strobe up, wait answer
      LBP_S_LOW   = 7'h08,                      // strobe down, wait release
      LBP_S_GRANT = 7'h10,                      // handing link to far end
      LBP_S_TREQ  = 7'h20,                      // asking far end for link
      LBP_S_TACQ  = 7'h40                       // waiting grant release
   } lbp_state_e;

   // byte k of a word, least significant byte first
   function automatic logic [7:0] lbp_byte_of(input logic [31:0] word,
                                              input logic [1:0]  k);
      lbp_byte_of = word[{k, 3'h0} +: 8];
   endfunction

endpackage

// >>> rtl/lbp_stream_if.sv
// Purpose: valid/ready word carrier between link port modules
// Assumes: all users on the same clock
// Notes:   a word moves on a cycle with valid and ready both high

`timescale 1ns/1ps

interface lbp_stream_if #(parameter int W = 32) ();
   logic         valid;                         // word offered
   logic         ready;                         // word accepted
   logic [W-1:0] data;                          // word value

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/lbp_fifo.sv
// Purpose: word fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full refuses writes by ready low, empty shows valid low

`timescale 1ns/1ps

module lbp_fifo
   import lbp_pkg::*;
#(
   parameter int W     = 32,
   parameter int DEPTH = 8
)(
   input wire logic   clk_i,
   input wire logic   rst_n_i,
   lbp_stream_if.snk  wr,
   lbp_stream_if.src  rd
);
   localparam int         AW   = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;             // storage words
      logic [AW-1:0]           wp;              // write index
      logic [AW-1:0]           rp;              // read index
      logic [AW:0]             cnt;             // words held
      logic                    rdy;             // room for a word
      logic                    vld;             // a word is held
      logic [W-1:0]            head;            // oldest word
   } lbp_fifo_s;

   lbp_fifo_s s;                                // registered state
   lbp_fifo_s next_s;                           // next state
   logic      push;                             // word written
   logic      pop;                              // word read

   assign wr.ready = s.rdy;
   assign rd.valid = s.vld;
   assign rd.data  = s.head;
   assign push     = wr.valid & wr.ready;
   assign pop      = rd.valid & rd.ready;

   // pointer and count update
   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.mem[s.wp] = wr.data;
         next_s.wp        = s.wp + 1'b1;
      end
      if (pop)
      begin
         next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // flags and head kept in flops so port outputs need no logic
      next_s.rdy  = (next_s.cnt != FULL);
      next_s.vld  = (next_s.cnt != '0);
      next_s.head = next_s.mem[next_s.rp];
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s     <= '0;
         s.rdy <= 1'b1;                         // empty fifo takes words
      end
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_FIFO_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s.cnt <= FULL) else $error("fifo count above depth");
   AST_FIFO_COUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      push && !pop |=> s.cnt == $past(s.cnt) + 1'b1)
      else $error("fifo count missed a write");
endmodule

// >>> sim/lbp_far_model.sv
// Purpose: behavioural far end port for the byte link bench
// Assumes: lines resolved with pull-downs and fed back on ctl_i, ld_i
// Notes:   bench loads txq and reads rxq; lag delays each answer

`timescale 1ns/1ps

module lbp_far_model
   import lbp_pkg::*;
(
   input  wire logic       clk_i,    // bench clock
   input  wire logic       rst_n_i,  // active low reset
   input  wire logic [3:0] ctl_i,    // resolved control lines
   input  wire logic [7:0] ld_i,     // resolved data lines
   output logic      [3:0] ctl_o,    // lines driven high
   output logic      [7:0] ld_o,     // byte driven
   output logic            ld_en_o   // data pins driven
);
   logic [31:0] txq[$];              // words to send
   logic [31:0] rxq[$];              // words collected
   int          lag  = 0;            // answer delay, cycles
   int          sent = 0;            // words sent
   bit          own  = 0;            // link owned here
   bit          bad  = 0;            // a wait ran out

   // ----------------------------------------------------------------
   // handshake helpers
   // ----------------------------------------------------------------
   // bounded wait for a line level
   task automatic wt(input int i, input logic v);
      int n;
      n = 0;
      while (ctl_i[i] !== v && n < 4000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 4000)
         bad = 1'b1;
   endtask

   // answer one phase, byte taken while strobe is high
   task automatic rcv(output logic [7:0] b);
      wt(LBP_CTL_STRB, 1'b1);
      repeat (lag) @(posedge clk_i);
      b = ld_i;
      ctl_o[LBP_CTL_RDY] <= 1'b1;
      @(posedge clk_i);
      wt(LBP_CTL_STRB, 1'b0);
      ctl_o[LBP_CTL_RDY] <= 1'b0;
      @(posedge clk_i);
   endtask

   // request phase, then bytes low to high; queue never fills
   task automatic rcv_word();
      logic [7:0]  b;
      logic [31:0] w;
      rcv(b);
      for (int k = 0; k < 4; k++)
      begin
         rcv(b);
         w[8*k +: 8] = b;
      end
      rxq.push_back(w);
   endtask

   // one sending phase, data set a cycle before strobe
   task automatic snd(input bit d, input logic [7:0] b);
      if (d)
      begin
         ld_o    <= b;
         ld_en_o <= 1'b1;
         @(posedge clk_i);
      end
      ctl_o[LBP_CTL_STRB] <= 1'b1;
      @(posedge clk_i);
      wt(LBP_CTL_RDY, 1'b1);
      ctl_o[LBP_CTL_STRB] <= 1'b0;
      @(posedge clk_i);
      wt(LBP_CTL_RDY, 1'b0);
      ld_en_o <= 1'b0;
      @(posedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // main loop: grant, send, request or receive
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] w;
      ctl_o   = 4'h0;
      ld_o    = 8'h00;
      ld_en_o = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (!rst_n_i)
            own = 1'b0;
         else if (own && ctl_i[LBP_CTL_TREQ] === 1'b1)
         begin
            ctl_o[LBP_CTL_TGNT] <= 1'b1;
            @(posedge clk_i);
            wt(LBP_CTL_TREQ, 1'b0);
            ctl_o[LBP_CTL_TGNT] <= 1'b0;
            own = 1'b0;
            @(posedge clk_i);
         end
         else if (own && txq.size() > 0)
         begin
            w = txq.pop_front();
            snd(1'b0, 8'h00);
            for (int k = 0; k < 4; k++)
               snd(1'b1, w[8*k +: 8]);
            sent++;
         end
         else if (!own && txq.size() > 0)
         begin
            ctl_o[LBP_CTL_TREQ] <= 1'b1;
            @(posedge clk_i);
            while (ctl_i[LBP_CTL_TGNT] !== 1'b1)
               if (ctl_i[LBP_CTL_STRB] === 1'b1)
                  rcv_word();
               else
                  @(posedge clk_i);
            ctl_o[LBP_CTL_TREQ] <= 1'b0;
            @(posedge clk_i);
            wt(LBP_CTL_TGNT, 1'b0);
            own = 1'b1;
         end
         else if (!own && ctl_i[LBP_CTL_STRB] === 1'b1)
            rcv_word();
      end
   end
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench of the byte link port against a far model
// Assumes: released lines read low, far model starts as non-owner
// Notes:   random words from a fixed seed, corner words first

`timescale 1ns/1ps

module tb
   import lbp_pkg::*;
;
   logic        clk = 0;             // bench clock
   logic        rst_n = 0;           // active low reset
   logic [31:0] txd = 0;             // word offered
   logic        txv = 0;             // offer valid
   logic        rxr = 0;             // take head word
   wire  [31:0] rxd;                 // head word
   wire         rxv, txr, own;       // fifo flags, owner
   wire  [3:0]  ctl_o, ctl_oe_n;     // design control lines
   wire  [3:0]  f_ctl;               // far control lines
   wire  [7:0]  ld_o, f_ld;          // data bytes
   wire         ld_oe_n, f_ld_en;    // data enables
   wire  [3:0]  ctl_w = (ctl_o & ~ctl_oe_n) | f_ctl;                 // pull-down
   wire  [7:0]  ld_w = !ld_oe_n ? ld_o : (f_ld_en ? f_ld : 8'h00); // pull-down
   logic [31:0] sq[$], rq[$];        // expected words
   int          err_count = 0;
   int          cmp_count = 0;

   always #20 clk = ~clk;

   lbp_port #(.OWN_AT_RESET(1'b1), .DEPTH(LBP_FIFO_DEPTH)) DUT
   (
      .CLK_I(clk), .RST_N_I(rst_n), .TXW_DATA_I(txd), .TXW_VALID_I(txv),
      .TXW_READY_O(txr), .RXW_DATA_O(rxd), .RXW_VALID_O(rxv), .RXW_READY_I(rxr),
      .CTL_I(ctl_w), .CTL_O(ctl_o), .CTL_OE_N_O(ctl_oe_n), .LD_I(ld_w),
      .LD_O(ld_o), .LD_OE_N_O(ld_oe_n), .OWNER_O(own)
   );

   lbp_far_model FAR
   (
      .clk_i(clk), .rst_n_i(rst_n), .ctl_i(ctl_w), .ld_i(ld_w),
      .ctl_o(f_ctl), .ld_o(f_ld), .ld_en_o(f_ld_en)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // corner words first, random after
   function automatic logic [31:0] pick(input int k);
      logic [31:0] c[4] = '{32'h00000000, 32'hFFFFFFFF, 32'h01020304, 32'h80000001};
      return (k < 4) ? c[k] : $urandom();
   endfunction

   // offer a word, valid left high for back-to-back use
   task automatic put(input logic [31:0] w);
      @(negedge clk);
      txd = w;
      txv = 1'b1;
      @(posedge clk);
      for (int n = 0; n < 5000 && txr !== 1'b1; n++)
         @(posedge clk);
      if (txr !== 1'b1)
         err_count++;
   endtask

   // take one word from the input fifo
   task automatic get(output logic [31:0] w);
      @(negedge clk);
      rxr = 1'b1;
      @(posedge clk);
      for (int n = 0; n < 5000 && rxv !== 1'b1; n++)
         @(posedge clk);
      if (rxv !== 1'b1)
         err_count++;
      w = rxd;
      @(negedge clk);
      rxr = 1'b0;
   endtask

   task automatic wait_far(input int n);
      for (int i = 0; i < 5000 && FAR.rxq.size() < n; i++)
         @(posedge clk);
      if (FAR.rxq.size() < n)
         err_count++;
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      results();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] w;
      int          hits;
      w = $urandom(81906);
      repeat (12) @(negedge clk);
      check("ctl_o", 32'(ctl_o), 32'(LBP_CTL_RST));
      check("ctl_oe_n", 32'(ctl_oe_n), 32'(LBP_CTL_OFF));
      check("ld_oe_n", 32'(ld_oe_n), 32'(LBP_OE_OFF));
      check("owner", 32'(own), 32'h1);
      check("txw ready", 32'(txr), 32'h1);
      check("rxw valid", 32'(rxv), 32'h0);
      check("ctl width", 32'($bits(DUT.CTL_O)), 32'h4);
      check("ld width", 32'($bits(DUT.LD_O)), 32'h8);
      rst_n = 1'b1;
      repeat (30) @(negedge clk);
      check("idle strobe", 32'(ctl_o[LBP_CTL_STRB]), 32'h0);
      $display("test reset done");
      FAR.lag = 400;
      for (int k = 0; k < 8; k++)
      begin
         w = pick(k);
         sq.push_back(w);
         put(w);
      end
      @(negedge clk);
      txd = pick(8);
      repeat (4) @(negedge clk);
      check("txw ready full", 32'(txr), 32'h0);
      txv = 1'b0;
      FAR.lag = 0;
      wait_far(8);
      repeat (100) @(posedge clk);
      check("far count", 32'(FAR.rxq.size()), 32'h8);
      while (sq.size() > 0)
         check("far word", FAR.rxq.pop_front(), sq.pop_front());
      $display("test send done");
      for (int k = 0; k < 9; k++)
      begin
         w = pick(k + 2);
         rq.push_back(w);
         FAR.txq.push_back(w);
      end
      for (int i = 0; i < 5000 && FAR.sent < 8; i++)
         @(posedge clk);
      check("owner far", 32'(own), 32'h0);
      hits = 0;
      repeat (150)
      begin
         @(negedge clk);
         hits += ctl_o[LBP_CTL_RDY] ? 1 : 0;
      end
      check("answer full", 32'(hits), 32'h0);
      for (int k = 0; k < 9; k++)
      begin
         get(w);
         check("rx word", w, rq.pop_front());
      end
      repeat (2) @(negedge clk);
      check("rxw empty", 32'(rxv), 32'h0);
      $display("test receive done");
      for (int k = 0; k < 3; k++)
      begin
         w = pick(k + 4);
         sq.push_back(w);
         put(w);
      end
      @(negedge clk);
      txv = 1'b0;
      wait_far(3);
      check("owner back", 32'(own), 32'h1);
      while (sq.size() > 0)
         check("back word", FAR.rxq.pop_front(), sq.pop_front());
      check("far waits", 32'(FAR.bad), 32'h0);
      $display("test handover done");
      results();
   end
endmodule
